// [pkg/cbcs_defs.vh]
`ifndef CBCS_DEFS_VH
`define CBCS_DEFS_VH

// Width of the horizontal sync pulse counter.
`define CBCS_CNT_W 5

// Counted sync pulse numbers that move the outputs.
`define CBCS_QUIET_LAST 5'h0D
`define CBCS_BIAS_START 5'h0E
`define CBCS_SETUP_START 5'h0F
`define CBCS_MEAS_START 5'h12
`define CBCS_CYCLE_END 5'h15

// Lengths in horizontal line periods.
`define CBCS_BIAS_LINES 5'h07
`define CBCS_SETUP_LINES 5'h03

// Output levels while no bias cycle is under way.
`define CBCS_AUTO_BIAS_IDLE 1'h0
`define CBCS_GRID_IDLE 1'h1
`define CBCS_PROGRAM_IDLE 1'h1

// Reset value of the counter.
`define CBCS_CNT_RESET 5'h00

`endif

// [design/cbcs_edge_detect.v]
`timescale 1ns/1ps

// Finds the rising edge of a level that is already synchronous to clk.
module cbcs_edge_detect #(
    parameter IDLE_LEVEL = 1'h0
) (
    input wire clk,
    input wire rstn,
    input wire level,
    output wire rise
);
    reg level_q;

    // Previous sample of the level; reset to its idle value so no false edge appears.
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            level_q <= IDLE_LEVEL;
        end else begin
            level_q <= level;
        end
    end

    // A rise lasts exactly one clock cycle.
    assign rise = level & ~level_q;
endmodule // cbcs_edge_detect

// [design/cbcs_sequencer.v]
// Operation
// - Count syncs in retrace; outputs idle first thirteen.
// - Fourteenth sync raises the auto-bias output.
// - Auto-bias stays high seven lines, then drops.
// - Fifteenth sync starts setup, grid pulse active.
// - Setup lasts three lines, syncs fifteen to seventeen.
// - Eighteenth sync drives grid high, measurement starts.
// - Program pulse goes low with grid high.
`timescale 1ns/1ps
`include "cbcs_defs.vh"

module cbcs_sequencer #(
    parameter CNT_W = `CBCS_CNT_W,
    parameter [CNT_W-1:0] BIAS_START = `CBCS_BIAS_START,
    parameter [CNT_W-1:0] SETUP_START = `CBCS_SETUP_START,
    parameter [CNT_W-1:0] MEAS_START = `CBCS_MEAS_START,
    parameter [CNT_W-1:0] CYCLE_END = `CBCS_CYCLE_END
) (
    input wire clk,
    input wire rstn,
    input wire hsync,
    input wire vretrace,
    output reg auto_bias,
    output reg grid_pulse,
    output reg program_pulse,
    output reg cycle_busy,
    output reg cycle_done,
    output reg cycle_abort,
    output reg [CNT_W-1:0] line_count
);
    // One-hot states of the bias cycle.
    localparam [4:0] ST_IDLE = 5'h01;
    localparam [4:0] ST_QUIET = 5'h02;
    localparam [4:0] ST_BIAS = 5'h04;
    localparam [4:0] ST_SETUP = 5'h08;
    localparam [4:0] ST_MEAS = 5'h10;

    // Count step, sized to the counter so no bits are dropped in the sum.
    localparam [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'h0}}, 1'h1};

    reg [4:0] state;
    reg [4:0] next_state;
    reg [CNT_W-1:0] count;
    reg [CNT_W-1:0] next_count;
    reg [CNT_W-1:0] count_inc;
    reg next_done;
    reg next_abort;
    reg next_auto_bias;
    reg next_grid_pulse;
    reg next_program_pulse;
    reg next_busy;

    wire hsync_rise;
    wire retrace_rise;

    // Edge of each horizontal sync pulse; one edge is one counted pulse.
    cbcs_edge_detect #(
        .IDLE_LEVEL(1'h0)
    ) u_hsync_edge (
        .clk(clk),
        .rstn(rstn),
        .level(hsync),
        .rise(hsync_rise)
    );

    // Start of the vertical retrace interval.
    cbcs_edge_detect #(
        .IDLE_LEVEL(1'h0)
    ) u_retrace_edge (
        .clk(clk),
        .rstn(rstn),
        .level(vretrace),
        .rise(retrace_rise)
    );

    // Maps a pulse number onto the phase of the cycle it belongs to.
    function [4:0] phase_of;
        input [CNT_W-1:0] num;
        begin
            if (num >= CYCLE_END) begin
                phase_of = ST_IDLE;
            end else if (num >= MEAS_START) begin
                phase_of = ST_MEAS;
            end else if (num >= SETUP_START) begin
                phase_of = ST_SETUP;
            end else if (num >= BIAS_START) begin
                phase_of = ST_BIAS;
            end else begin
                phase_of = ST_QUIET;
            end
        end
    endfunction

    // Next state and count. A new retrace always wins and restarts the count.
    always @* begin
        next_state = state;
        next_count = count;
        next_done = 1'h0;
        next_abort = 1'h0;
        count_inc = count + CNT_ONE;
        if (retrace_rise) begin
            // A sync edge in the same cycle as the retrace start is the first one counted.
            next_count = hsync_rise ? CNT_ONE : {CNT_W{1'h0}};
            next_state = hsync_rise ? phase_of(CNT_ONE) : ST_QUIET;
            next_abort = ~state[0];
        end else begin
            case (state)
                ST_IDLE: begin
                    // Syncs after the last pulse are ignored; the count holds.
                    next_state = ST_IDLE;
                end
                ST_QUIET: begin
                    if (hsync_rise) begin
                        // Pulses one to thirteen leave every cycle output idle; cycle_busy stays high.
                        next_count = count_inc;
                        next_state = phase_of(count_inc);
                    end
                end
                ST_BIAS: begin
                    if (hsync_rise) begin
                        next_count = count_inc;
                        next_state = phase_of(count_inc);
                    end
                end
                ST_SETUP: begin
                    if (hsync_rise) begin
                        // Setup holds for pulses fifteen, sixteen and seventeen.
                        next_count = count_inc;
                        next_state = phase_of(count_inc);
                    end
                end
                ST_MEAS: begin
                    if (hsync_rise) begin
                        next_count = count_inc;
                        next_state = phase_of(count_inc);
                        next_done = (count_inc >= CYCLE_END);
                    end
                end
                default: begin
                    next_state = ST_IDLE;
                    next_count = {CNT_W{1'h0}};
                end
            endcase
        end
    end

    // Output levels that belong to the next phase; anything else keeps idle levels.
    always @* begin
        next_auto_bias = `CBCS_AUTO_BIAS_IDLE;
        next_grid_pulse = `CBCS_GRID_IDLE;
        next_program_pulse = `CBCS_PROGRAM_IDLE;
        next_busy = 1'h0;
        case (next_state)
            ST_QUIET: begin
                // Pulses one to thirteen only count; every cycle output stays idle.
                next_busy = 1'h1;
            end
            ST_BIAS: begin
                // Blanks the external drive to black from pulse fourteen.
                next_auto_bias = 1'h1;
                next_busy = 1'h1;
            end
            ST_SETUP: begin
                // Auto-bias stays high; the low grid level raises cathode current.
                next_auto_bias = 1'h1;
                next_grid_pulse = 1'h0;
                next_busy = 1'h1;
            end
            ST_MEAS: begin
                // Grid returns high and the program pulse drops in the same cycle.
                next_auto_bias = 1'h1;
                next_grid_pulse = 1'h1;
                next_program_pulse = 1'h0;
                next_busy = 1'h1;
            end
            default: begin
                // Idle after the last pulse: auto-bias low ends the bias cycle.
                next_auto_bias = `CBCS_AUTO_BIAS_IDLE;
            end
        endcase
    end

    // State and counter registers.
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state <= ST_IDLE;
            count <= `CBCS_CNT_RESET;
        end else begin
            state <= next_state;
            count <= next_count;
        end
    end

    // Outputs are registered from the next state so they move with the counted edge.
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            auto_bias <= `CBCS_AUTO_BIAS_IDLE;
            grid_pulse <= `CBCS_GRID_IDLE;
            program_pulse <= `CBCS_PROGRAM_IDLE;
        end else begin
            // High from pulse fourteen until pulse twenty-one, seven lines.
            auto_bias <= next_auto_bias;
            // Low during setup to raise cathode current; high again at measurement.
            grid_pulse <= next_grid_pulse;
            // Low for the whole measurement phase, released at cycle end.
            program_pulse <= next_program_pulse;
        end
    end

    // Status outputs for the surrounding logic.
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cycle_busy <= 1'h0;
            cycle_done <= 1'h0;
            cycle_abort <= 1'h0;
            line_count <= `CBCS_CNT_RESET;
        end else begin
            cycle_busy <= next_busy;
            cycle_done <= next_done;
            cycle_abort <= next_abort;
            line_count <= next_count;
        end
    end
endmodule // cbcs_sequencer

// [tb/cbcs_seq_asserts.sv]
`timescale 1ns/1ps
// Ties each cycle output to the sync count that should move it.
module cbcs_seq_chk #(parameter CNT_W = 5) (
    input logic clk,
    input logic rstn,
    input logic vretrace,
    input logic auto_bias,
    input logic grid_pulse,
    input logic program_pulse,
    input logic cycle_busy,
    input logic cycle_done,
    input logic cycle_abort,
    input logic [CNT_W-1:0] line_count
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    chk_quiet_start: assert property (
        line_count < 5'h0E |-> !auto_bias && grid_pulse && program_pulse)
        else $error("output active early");
    chk_bias_level: assert property (
        cycle_busy && line_count >= 5'h0E |-> auto_bias) else $error("bias low");
    chk_bias_end: assert property (
        $fell(auto_bias) && !cycle_abort |-> line_count == 5'h15 && cycle_done)
        else $error("bias end wrong");
    chk_setup_span: assert property (
        !grid_pulse |-> cycle_busy && line_count inside {[5'h0F:5'h11]})
        else $error("setup span wrong");
    chk_setup_start: assert property (
        cycle_busy && line_count == 5'h0F |-> !grid_pulse) else $error("no setup");
    chk_meas_start: assert property (
        $rose(grid_pulse) && !cycle_abort |-> line_count == 5'h12 && $fell(program_pulse))
        else $error("measure start wrong");
    chk_prog_with_grid: assert property (
        !program_pulse |-> grid_pulse && auto_bias) else $error("program low alone");
    chk_count_restart: assert property (
        $rose(vretrace) |=> cycle_busy && line_count <= 5'h01) else $error("no restart");
    cov_done: cover property (cycle_done);
    cov_abort: cover property (cycle_abort);
    cov_measure: cover property ($fell(program_pulse));
endmodule // cbcs_seq_chk

bind cbcs_sequencer cbcs_seq_chk #(.CNT_W(CNT_W)) i_chk(.clk(clk), .rstn(rstn),
    .vretrace(vretrace), .auto_bias(auto_bias), .grid_pulse(grid_pulse),
    .program_pulse(program_pulse), .cycle_busy(cycle_busy), .cycle_done(cycle_done),
    .cycle_abort(cycle_abort), .line_count(line_count));

// [tb/cbcs_sync_src.sv]
`timescale 1ns/1ps
// Sync source; each drive call sets both levels and holds them one clock.
module cbcs_sync_src (
    input logic clk,
    output logic hsync,
    output logic vretrace
);
    initial begin
        hsync = 1'h0;
        vretrace = 1'h0;
    end
    // Called at a falling edge so the levels settle before the next rising edge.
    task automatic drive(input logic h, input logic v);
        hsync = h;
        vretrace = v;
        @(negedge clk);
    endtask
endmodule // cbcs_sync_src

// [tb/tb.sv]
`timescale 1ns/1ps
module tb;
    logic clk, rstn;
    wire hsync, vretrace, auto_bias, grid_pulse, program_pulse;
    wire cycle_busy, cycle_done, cycle_abort;
    wire [4:0] line_count;
    int bad_count, cmp_count;
    cbcs_sync_src i_src(.clk(clk), .hsync(hsync), .vretrace(vretrace));
    cbcs_sequencer i_dut(.clk(clk), .rstn(rstn), .hsync(hsync), .vretrace(vretrace),
        .auto_bias(auto_bias), .grid_pulse(grid_pulse), .program_pulse(program_pulse),
        .cycle_busy(cycle_busy), .cycle_done(cycle_done), .cycle_abort(cycle_abort),
        .line_count(line_count));
    // Free running 200 MHz clock.
    initial begin
        clk = 1'h0;
        forever #2.5 clk = ~clk;
    end
    // Counts one comparison and reports it when the seen value differs.
    task automatic chk(input string nm, input logic [4:0] seen, input logic [4:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s exp %0h seen %0h", nm, exp, seen);
        end
    endtask
    // One retrace then n sync pulses, each checked after the edge that counts it.
    // With same set, the first sync rises on the retrace start edge itself.
    task automatic frame(input int n, input logic ab, input logic same);
        int i;
        i_src.drive(same, 1'h1);
        chk("abort", cycle_abort, ab);
        chk("count0", line_count, {4'h0, same});
        chk("busy0", cycle_busy, 5'h01);
        if (same)
            i_src.drive(1'h0, 1'h1);
        for (i = 1 + same; i <= n; i++) begin
            i_src.drive(1'h1, 1'h1);
            chk("abort_end", cycle_abort, 5'h00);
            chk("busy", cycle_busy, i < 21);
            chk("count", line_count, (i > 21) ? 5'h15 : 5'(i));
            chk("bias", auto_bias, i >= 14 && i <= 20);
            chk("grid", grid_pulse, !(i >= 15 && i <= 17));
            chk("prog", program_pulse, !(i >= 18 && i <= 20));
            chk("done", cycle_done, i == 21);
            i_src.drive(1'h0, 1'h1);
        end
        i_src.drive(1'h0, 1'h0);
    endtask
    // Full cycle, with extra syncs after the end that must be ignored.
    task automatic test_full_cycle;
        frame(23, 1'h0, 1'h0);
    endtask
    // A new retrace in mid-setup aborts, then a full cycle runs from pulse one.
    task automatic test_abort_restart;
        frame(16, 1'h0, 1'h0);
        frame(23, 1'h1, 1'h0);
    endtask
    // Reset in mid-measurement forces idle levels; a clean cycle follows release.
    task automatic test_reset_mid_cycle;
        frame(19, 1'h0, 1'h0);
        rstn = 1'h0;
        i_src.drive(1'h0, 1'h0);
        chk("rst_bias", auto_bias, 5'h00);
        chk("rst_grid", grid_pulse, 5'h01);
        chk("rst_prog", program_pulse, 5'h01);
        chk("rst_busy", cycle_busy, 5'h00);
        chk("rst_count", line_count, 5'h00);
        rstn = 1'h1;
        i_src.drive(1'h0, 1'h0);
        chk("rel_busy", cycle_busy, 5'h00);
        chk("rel_grid", grid_pulse, 5'h01);
        frame(23, 1'h0, 1'h0);
    endtask
    // Retrace start and first sync on one edge: that sync is pulse one.
    task automatic test_same_edge_start;
        frame(21, 1'h0, 1'h1);
    endtask
    // Prints the verdict and ends the run.
    task automatic print_verdict;
        if (bad_count == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Main sequence after a four cycle reset.
    initial begin
        rstn = 1'h0;
        repeat (4) @(negedge clk);
        rstn = 1'h1;
        @(negedge clk);
        test_full_cycle;
        test_abort_restart;
        test_reset_mid_cycle;
        test_same_edge_start;
        print_verdict;
    end
    // Watchdog well beyond the expected run of about 270 clocks.
    initial begin
        #5000;
        bad_count++;
        print_verdict;
    end
endmodule // tb
